// ### rtl/rst_boot_pkg.sv
// shared constants and types for the reset, bootstrap and system-clock setup block
package rst_boot_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing, figures in their own unit, cycles derived from the clock rate
    localparam int CLK_MHZ = 100;
    localparam int RESET_MIN_US = 50;
    localparam int STRAP_HOLD_US = 2000;
    localparam int NO_LOAD_STABLE_US = 10000;
    localparam int LOAD_STABLE_US = 100000;
    localparam int PLL_SETTLE_US = 1000;
    localparam int RESET_MIN_CYC = RESET_MIN_US * CLK_MHZ;
    localparam int STRAP_HOLD_CYC = STRAP_HOLD_US * CLK_MHZ;
    localparam int NO_LOAD_STABLE_CYC = NO_LOAD_STABLE_US * CLK_MHZ;
    localparam int LOAD_STABLE_CYC = LOAD_STABLE_US * CLK_MHZ;
    localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
    localparam logic [1:0] LOAD_TRIES = 2'h3;
    localparam int TRIM_RANGE_PPM = 741;

    ////////////////////////////////////////////////////////////////////////////
    // register map and fields
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_OSC_CFG = 8'h00;
    localparam logic [7:0] ADDR_TRIM = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_STRAPS = 8'h0c;
    localparam logic [7:0] ADDR_FREQ = 8'h10;
    localparam int OSC_CODE_LSB = 0;
    localparam int OSC_CODE_W = 3;
    localparam int EDGE_BIT = 3;
    localparam int TRIM_W = 24;
    localparam int FREQ_W = 16;
    localparam logic [2:0] OSC_CODE_RESET = 3'h0;
    localparam logic EDGE_RESET = 1'b0;
    localparam logic [23:0] TRIM_RESET = 24'h000000;
    localparam int ST_STABLE_BIT = 0;
    localparam int ST_HALT_BIT = 1;
    localparam int ST_LOADING_BIT = 2;
    localparam int ST_FAILS_LSB = 3;
    localparam int ST_EEPROM_BIT = 5;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic eeprom_load;
        logic transport_standard_strap;
        logic redundancy_role_strap;
        logic [2:0] bus_addr;
        logic [1:0] host_port_select;
        logic [2:0] osc_freq_straps;
    } strap_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef enum {
        SEQ_STRAP, SEQ_LOAD_REQ, SEQ_LOAD_WAIT, SEQ_SETTLE, SEQ_STABLE, SEQ_HALT
    } seq_state_e;

    // oscillator code to nominal frequency in kHz
    function automatic logic [15:0] freq_khz(input logic [2:0] code);
        case (code)
            3'h0: freq_khz = 16'd10000;
            3'h1: freq_khz = 16'd12800;
            3'h2: freq_khz = 16'd13000;
            3'h3: freq_khz = 16'd19440;
            3'h4: freq_khz = 16'd20000;
            3'h5: freq_khz = 16'd24576;
            3'h6: freq_khz = 16'd25000;
            default: freq_khz = 16'd30720;
        endcase
    endfunction

endpackage

// ### rtl/reset_bootstrap_sysclk_setup.sv
// reset sequencing, strap capture, configuration load retries and system-clock setup
`timescale 1ns/1ps
module reset_bootstrap_sysclk_setup
    import rst_boot_pkg::*;
#(
    parameter int STRAP_HOLD = STRAP_HOLD_CYC,
    parameter int NO_LOAD_STABLE = NO_LOAD_STABLE_CYC,
    parameter int LOAD_STABLE = LOAD_STABLE_CYC,
    parameter int PLL_SETTLE = PLL_SETTLE_CYC
) (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire strap_s STRAPS,
    input wire reg_req_s REG_REQ,
    output logic [31:0] REG_RDATA,
    input wire logic SYSCLK_INPUT,
    output logic SYSCLK_TICK,
    output logic LOAD_START,
    input wire logic LOAD_DONE,
    input wire logic LOAD_FAIL,
    output logic CLOCKS_STABLE,
    output logic DEVICE_HALTED,
    output logic [2:0] OSC_FREQ_CONFIG,
    output logic [15:0] OSC_FREQ_KHZ,
    output logic [23:0] NOMINAL_FREQ_TRIM
);

    // each load attempt gets the share of the bound left after straps and settling
    localparam int LOAD_WINDOW = LOAD_STABLE - STRAP_HOLD - PLL_SETTLE - 4;

    seq_state_e state;
    logic [31:0] phase_cnt;
    logic [31:0] elapsed;
    logic [1:0] fails;
    logic eeprom_mode;
    strap_s strap_latch;
    logic sysclk_edge_select;
    logic sysclk_prev;
    logic strap_take;
    logic wr_osc;
    logic wr_trim;
    logic load_bad;

    assign strap_take = (state == SEQ_STRAP) && (phase_cnt == 32'(STRAP_HOLD - 1));
    assign wr_osc = REG_REQ.wr && (REG_REQ.addr == ADDR_OSC_CFG);
    assign wr_trim = REG_REQ.wr && (REG_REQ.addr == ADDR_TRIM);
    assign load_bad = LOAD_FAIL || (phase_cnt == 32'(LOAD_WINDOW - 1));

    ////////////////////////////////////////////////////////////////////////////
    // time since release, saturating
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            elapsed <= 32'h0;
        end else if (elapsed != 32'hffffffff) begin
            elapsed <= elapsed + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-up sequence
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            state <= SEQ_STRAP;
            phase_cnt <= 32'h0;
            fails <= 2'h0;
            LOAD_START <= 1'b0;
        end else begin
            LOAD_START <= 1'b0;
            phase_cnt <= phase_cnt + 32'h1;
            case (state)
                SEQ_STRAP: begin
                    if (strap_take) begin
                        phase_cnt <= 32'h0;
                        state <= STRAPS.eeprom_load ? SEQ_LOAD_REQ : SEQ_SETTLE;
                    end
                end
                SEQ_LOAD_REQ: begin
                    LOAD_START <= 1'b1;
                    phase_cnt <= 32'h0;
                    state <= SEQ_LOAD_WAIT;
                end
                SEQ_LOAD_WAIT: begin
                    if (LOAD_DONE && !LOAD_FAIL) begin
                        phase_cnt <= 32'h0;
                        state <= SEQ_SETTLE;
                    end else if (load_bad) begin
                        fails <= fails + 2'h1;
                        state <= (fails == LOAD_TRIES - 2'h1) ? SEQ_HALT : SEQ_LOAD_REQ;
                    end
                end
                SEQ_SETTLE: begin
                    if (phase_cnt == 32'(PLL_SETTLE - 1)) begin
                        state <= SEQ_STABLE;
                    end
                end
                SEQ_STABLE: phase_cnt <= 32'h0;
                SEQ_HALT: phase_cnt <= 32'h0;
                default: state <= SEQ_HALT;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            CLOCKS_STABLE <= 1'b0;
            DEVICE_HALTED <= 1'b0;
        end else begin
            CLOCKS_STABLE <= (state == SEQ_STABLE);
            DEVICE_HALTED <= (state == SEQ_HALT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap capture, late in the hold window so slow pull-ups have settled
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            strap_latch <= '0;
            eeprom_mode <= 1'b0;
        end else if (strap_take) begin
            strap_latch <= STRAPS;
            eeprom_mode <= STRAPS.eeprom_load;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator configuration and trim
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            OSC_FREQ_CONFIG <= OSC_CODE_RESET;
            sysclk_edge_select <= EDGE_RESET;
        end else begin
            if (strap_take) begin
                OSC_FREQ_CONFIG <= STRAPS.osc_freq_straps;
            end else if (wr_osc) begin
                OSC_FREQ_CONFIG <= REG_REQ.wdata[OSC_CODE_LSB +: OSC_CODE_W];
            end
            if (wr_osc) begin
                sysclk_edge_select <= REG_REQ.wdata[EDGE_BIT];
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            OSC_FREQ_KHZ <= freq_khz(OSC_CODE_RESET);
        end else begin
            OSC_FREQ_KHZ <= freq_khz(OSC_FREQ_CONFIG);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            NOMINAL_FREQ_TRIM <= TRIM_RESET;
        // offset trim, full scale is the calibration range
        end else if (wr_trim) begin
            NOMINAL_FREQ_TRIM <= REG_REQ.wdata[TRIM_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // active edge of the system-clock input, as a one-cycle enable
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            sysclk_prev <= 1'b0;
            SYSCLK_TICK <= 1'b0;
        end else begin
            sysclk_prev <= SYSCLK_INPUT;
            SYSCLK_TICK <= sysclk_edge_select ? (sysclk_prev && !SYSCLK_INPUT)
                                              : (!sysclk_prev && SYSCLK_INPUT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port, unmapped reads return zero
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            REG_RDATA <= 32'h0;
        end else if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                ADDR_OSC_CFG: REG_RDATA <= {28'h0, sysclk_edge_select, OSC_FREQ_CONFIG};
                ADDR_TRIM: REG_RDATA <= {8'h0, NOMINAL_FREQ_TRIM};
                ADDR_STATUS: REG_RDATA <= {26'h0, eeprom_mode, fails,
                                           state == SEQ_LOAD_WAIT, DEVICE_HALTED,
                                           CLOCKS_STABLE};
                ADDR_STRAPS: REG_RDATA <= {21'h0, strap_latch};
                ADDR_FREQ: REG_RDATA <= {16'h0, OSC_FREQ_KHZ};
                default: REG_RDATA <= 32'h0;
            endcase
        end else begin
            REG_RDATA <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_last_fail;
        state == SEQ_LOAD_WAIT && !(LOAD_DONE && !LOAD_FAIL) && load_bad && fails == 2'h2;
    endsequence

    sequence s_halted_for_good;
        ##2 DEVICE_HALTED [*4] ##0 !CLOCKS_STABLE;
    endsequence

    property p_stable_no_load;
        @(posedge REF_CLK) disable iff (!RESET_N)
        ($rose(CLOCKS_STABLE) && !eeprom_mode) |-> elapsed <= 32'(NO_LOAD_STABLE);
    endproperty
    a_stable_no_load: assert property (p_stable_no_load)
        else $error("stable clocks late without eeprom load");

    property p_stable_first_load;
        @(posedge REF_CLK) disable iff (!RESET_N)
        $rose(CLOCKS_STABLE) && eeprom_mode && fails == 2'h0
            |-> elapsed <= 32'(LOAD_STABLE);
    endproperty
    a_stable_first_load: assert property (p_stable_first_load)
        else $error("stable clocks late after first load");

    property p_stable_retry;
        @(posedge REF_CLK) disable iff (!RESET_N)
        $rose(CLOCKS_STABLE) && fails != 2'h0
            |-> elapsed <= 32'(LOAD_STABLE) * (32'(fails) + 32'h1);
    endproperty
    a_stable_retry: assert property (p_stable_retry)
        else $error("stable clocks late after retry");

    property p_third_fail_halts;
        @(posedge REF_CLK) disable iff (!RESET_N)
        s_last_fail |-> s_halted_for_good;
    endproperty
    a_third_fail_halts: assert property (p_third_fail_halts)
        else $error("third failed load did not halt");

    property p_edge_tick;
        @(posedge REF_CLK) disable iff (!RESET_N)
        (sysclk_edge_select ? $fell(SYSCLK_INPUT) : $rose(SYSCLK_INPUT)) |=> SYSCLK_TICK;
    endproperty
    a_edge_tick: assert property (p_edge_tick)
        else $error("no tick on selected system-clock edge");

    property p_freq_map;
        @(posedge REF_CLK) disable iff (!RESET_N)
        ##1 OSC_FREQ_KHZ == freq_khz($past(OSC_FREQ_CONFIG));
    endproperty
    a_freq_map: assert property (p_freq_map)
        else $error("frequency does not follow oscillator code");

    property p_trim_write;
        @(posedge REF_CLK) disable iff (!RESET_N)
        wr_trim |=> NOMINAL_FREQ_TRIM == $past(REG_REQ.wdata[23:0]);
    endproperty
    a_trim_write: assert property (p_trim_write)
        else $error("trim write not taken");

    property p_strap_init;
        @(posedge REF_CLK) disable iff (!RESET_N)
        strap_take |=> OSC_FREQ_CONFIG == $past(STRAPS.osc_freq_straps);
    endproperty
    a_strap_init: assert property (p_strap_init)
        else $error("frequency field not loaded from straps");

    property p_sw_override;
        @(posedge REF_CLK) disable iff (!RESET_N)
        wr_osc && !strap_take |=> OSC_FREQ_CONFIG == $past(REG_REQ.wdata[2:0]);
    endproperty
    a_sw_override: assert property (p_sw_override)
        else $error("software write did not replace frequency field");

endmodule

// ### test/board_loader_model.sv
// board side model: strap settings and the external configuration loader
`timescale 1ns/1ps
module board_loader_model
    import rst_boot_pkg::*;
#(
    parameter int ANSWER_DELAY = 5
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [2:0] osc_code,
    input wire logic eeprom_mode,
    input wire logic [1:0] fails_to_give,
    input wire logic load_start,
    output strap_s straps,
    output logic load_done,
    output logic load_fail
);
    int wait_cnt;
    logic [1:0] given;

    ////////////////////////////////////////////////////////////////////////////
    // straps held steady
    assign straps = '{eeprom_load: eeprom_mode, transport_standard_strap: 1'b0,
                      redundancy_role_strap: 1'b1, bus_addr: 3'h2,
                      host_port_select: 2'h1, osc_freq_straps: osc_code};

    ////////////////////////////////////////////////////////////////////////////
    // answers each attempt late; first fails_to_give attempts go wrong
    always @(posedge clk) begin
        load_done <= 1'b0;
        load_fail <= 1'b0;
        if (!reset_n) begin
            wait_cnt <= 0;
            given <= 2'h0;
        end else if (load_start) begin
            wait_cnt <= ANSWER_DELAY;
        end else if (wait_cnt == 1) begin
            wait_cnt <= 0;
            if (given < fails_to_give) begin
                load_fail <= 1'b1;
                given <= given + 2'h1;
            end else begin
                load_done <= 1'b1;
            end
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule

// ### test/reset_bootstrap_sysclk_setup_tb_top.sv
// testbench for reset sequencing, strap capture and system-clock setup
`timescale 1ns/1ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected %s expected %0h seen %0h", what, exp, got); end end
module reset_bootstrap_sysclk_setup_tb_top;
    import rst_boot_pkg::*;
    // shortened counts keep the run short
    localparam int SH = 20;
    localparam int NL = 100;
    localparam int LS = 200;
    localparam int PS = 10;
    localparam logic [15:0] KHZ_TAB [8] = '{16'h2710, 16'h3200, 16'h32c8, 16'h4bf0,
                                            16'h4e20, 16'h6000, 16'h61a8, 16'h7800};
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic sysclk_input = 1'b0;
    logic [2:0] osc_code = 3'h5;
    logic eeprom_mode = 1'b0;
    logic [1:0] fails_to_give = 2'h0;
    reg_req_s req = '0;
    strap_s straps;
    logic [31:0] rdata;
    logic tick, load_start, load_done, load_fail, stable, halted;
    logic [2:0] cfg;
    logic [15:0] khz;
    logic [23:0] trim;
    logic [31:0] d;
    int failures = 0;
    int samples_checked = 0;
    int starts = 0;
    int n;

    reset_bootstrap_sysclk_setup #(.STRAP_HOLD(SH), .NO_LOAD_STABLE(NL),
        .LOAD_STABLE(LS), .PLL_SETTLE(PS)) u_dut (
        .REF_CLK(ref_clk), .RESET_N(reset_n), .STRAPS(straps), .REG_REQ(req),
        .REG_RDATA(rdata), .SYSCLK_INPUT(sysclk_input), .SYSCLK_TICK(tick),
        .LOAD_START(load_start), .LOAD_DONE(load_done), .LOAD_FAIL(load_fail),
        .CLOCKS_STABLE(stable), .DEVICE_HALTED(halted), .OSC_FREQ_CONFIG(cfg),
        .OSC_FREQ_KHZ(khz), .NOMINAL_FREQ_TRIM(trim));

    board_loader_model u_board (.clk(ref_clk), .reset_n(reset_n), .osc_code(osc_code),
        .eeprom_mode(eeprom_mode), .fails_to_give(fails_to_give), .load_start(load_start),
        .straps(straps), .load_done(load_done), .load_fail(load_fail));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            starts <= 0;
        end else if (load_start === 1'b1) begin
            starts <= starts + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [2:0] code, input logic ee, input logic [1:0] nf);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        osc_code <= code;
        eeprom_mode <= ee;
        fails_to_give <= nf;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
    endtask

    task automatic wait_settle(input int limit, output int cyc);
        cyc = 0;
        while (cyc < limit && stable !== 1'b1 && halted !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            cyc++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic count_ticks(input logic val, output int cnt);
        @(posedge ref_clk);
        sysclk_input <= val;
        cnt = 0;
        repeat (6) begin
            @(posedge ref_clk);
            #1;
            cnt += (tick === 1'b1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200us;
        failures++;
        end_sim();
    end

    initial begin
        do_reset(3'h5, 1'b0, 2'h0);
        wait_settle(NL, n);
        `CHK("stable_no_load", 1'b1, stable)
        `CHK("strap_window", 1'b1, n >= SH)
        `CHK("starts_no_load", 0, starts)
        `CHK("osc_from_straps", 3'h5, cfg)
        rd_reg(ADDR_OSC_CFG, d);
        `CHK("osc_cfg_read", 32'h00000005, d)
        rd_reg(8'h20, d);
        `CHK("unmapped_read", 32'h00000000, d)
        rd_reg(ADDR_STATUS, d);
        `CHK("status_no_load", 32'h00000001, d)
        rd_reg(ADDR_STRAPS, d);
        `CHK("straps_read", 32'h0000014d, d)
        for (int c = 0; c < 8; c++) begin
            wr_reg(ADDR_OSC_CFG, {28'h0, 1'b0, c[2:0]});
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK("osc_code", c[2:0], cfg)
            `CHK("osc_khz", KHZ_TAB[c], khz)
        end
        // rising edge first, then falling, under each select value
        for (int e = 0; e < 2; e++) begin
            wr_reg(ADDR_OSC_CFG, {28'h0, e[0], 3'h0});
            count_ticks(1'b1, n);
            `CHK("tick_on_rise", (e == 0) ? 1 : 0, n)
            count_ticks(1'b0, n);
            `CHK("tick_on_fall", (e == 1) ? 1 : 0, n)
        end
        wr_reg(ADDR_TRIM, 32'hff800001);
        rd_reg(ADDR_TRIM, d);
        `CHK("trim_out", 24'h800001, trim)
        `CHK("trim_read", 24'h800001, d[23:0])
        wr_reg(ADDR_FREQ, 32'h00001234);
        rd_reg(ADDR_FREQ, d);
        `CHK("freq_read_only", KHZ_TAB[0], d[15:0])
        // load with 0..3 failed attempts; third failure halts for good
        for (int f = 0; f < 4; f++) begin
            do_reset(3'h2, 1'b1, f[1:0]);
            wait_settle(3 * LS + PS, n);
            `CHK("load_time", 1'b1, n <= (f + 1) * LS)
            repeat (50) @(posedge ref_clk);
            #1;
            `CHK("load_stable", f < 3, stable)
            `CHK("load_halted", f == 3, halted)
            `CHK("load_tries", (f < 3) ? f + 1 : 3, starts)
            `CHK("load_osc_code", 3'h2, cfg)
            rd_reg(ADDR_STATUS, d);
            `CHK("load_status", (f < 3) ? (32'h21 | 32'(f << 3)) : 32'h3a, d)
        end
        end_sim();
    end
endmodule
